// ---- shared/cmpev_consts.vh ----
`ifndef CMPEV_CONSTS_VH
`define CMPEV_CONSTS_VH

// register map, byte addresses on the AXI4-Lite slave
`define CMPEV_ADDR_W 4
`define CMPEV_OFF_CTRL 4'h0
`define CMPEV_OFF_SYSOPT 4'h4

// status/control field positions
`define CMPEV_BIT_ENABLE 7
`define CMPEV_BIT_REFSEL 6
`define CMPEV_BIT_FLAG 5
`define CMPEV_BIT_IE 4
`define CMPEV_BIT_RESULT 3
`define CMPEV_BIT_PINEN 2
`define CMPEV_MODE_HI 1
`define CMPEV_MODE_LO 0

// event mode encodings
`define CMPEV_MODE_FALL0 2'h0
`define CMPEV_MODE_RISE 2'h1
`define CMPEV_MODE_FALL2 2'h2
`define CMPEV_MODE_BOTH 2'h3

// system option register fields
`define CMPEV_BIT_CAPROUTE 0

`define CMPEV_CTRL_RESET 8'h00
`define CMPEV_SYSOPT_RESET 1'h0

`define CMPEV_RESP_OKAY 2'h0
`define CMPEV_RESP_SLVERR 2'h2

`endif

// ---- src/cmpev_sync.v ----
`timescale 1ns/100ps
`default_nettype none

// two-flop synchroniser followed by a delay stage for edge detection
module cmpev_sync (
	input wire clk,
	input wire rst,
	input wire async_in,
	output reg sync_out,
	output reg sync_prev
);
	reg meta;

	always @(posedge clk) begin
		if (rst) begin
			meta <= 1'b0;
			sync_out <= 1'b0;
			sync_prev <= 1'b0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
			sync_prev <= sync_out;
		end
	end
endmodule

`default_nettype wire

// ---- src/cmpev_top.v ----
`timescale 1ns/100ps
`default_nettype none
`include "cmpev_consts.vh"

// What this block does
// - bit 7 switches the comparator on/off
// - bit 6 picks pin or internal reference
// - hardware sets flag on selected event
// - writing one clears flag, zero ignored
// - interrupt when flag and enable set
// - bit 3 live result, zero when off
// - bit 2 puts result on output pin
// - mode 00/10 fall, 01 rise, 11 both
// - result high when plus input exceeds minus
// - capture routing feeds timer channel zero
// - keeps running and interrupting in wait
// - keeps working and waking in stop3
// - reset out of stop gives reset state
// - stop2 powers off, wakes in reset state
// - runs normally during background debug
// - two software registers: 8-bit control, 1-bit system option
module cmpev_top (
	input wire SYS_CLK,
	input wire RESET,
	input wire STOP2_POWERDOWN,
	input wire CMP_RESULT_RAW,
	output wire CMP_POWER_ON,
	output wire REFERENCE_SELECT,
	output reg COMPARATOR_RESULT_PIN,
	output reg COMPARATOR_RESULT_PIN_OE,
	output reg TIMER_CAPTURE_IN,
	output reg TIMER_CHANNEL_ZERO_PIN_BLOCK,
	output wire IRQ,
	input wire [3:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [3:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY
);
	// control and system option register fields
	reg module_enable;
	reg ref_select;
	reg event_flag;
	reg int_enable;
	reg pin_enable;
	reg [1:0] event_mode;
	reg capture_route;

	// stop2 power-down acts as a reset of the whole block
	wire blk_rst = RESET | STOP2_POWERDOWN;

	wire res_now;
	wire res_prev;

	// comparator result: high when plus input above minus (analog side)
	cmpev_sync u_sync (
		.clk(SYS_CLK),
		.rst(blk_rst),
		.async_in(CMP_RESULT_RAW),
		.sync_out(res_now),
		.sync_prev(res_prev)
	);

	// result forced low while disabled
	wire result_bit = module_enable & res_now;
	wire prev_bit = module_enable & res_prev;

	function edge_hit;
		input [1:0] mode;
		input cur;
		input prv;
		begin
			case (mode)
				`CMPEV_MODE_RISE: edge_hit = cur & ~prv;
				`CMPEV_MODE_BOTH: edge_hit = cur ^ prv;
				default: edge_hit = ~cur & prv;
			endcase
		end
	endfunction

	// gated by enable only: no wait/stop3/debug input stalls detection
	wire event_hit = module_enable &
		edge_hit(event_mode, result_bit, prev_bit);

	assign CMP_POWER_ON = module_enable;
	assign REFERENCE_SELECT = ref_select;
	assign IRQ = event_flag & int_enable;

	always @(posedge SYS_CLK) begin
		if (blk_rst) begin
			COMPARATOR_RESULT_PIN <= 1'b0;
			COMPARATOR_RESULT_PIN_OE <= 1'b0;
			TIMER_CAPTURE_IN <= 1'b0;
			TIMER_CHANNEL_ZERO_PIN_BLOCK <= 1'b0;
		end else begin
			COMPARATOR_RESULT_PIN <= pin_enable & result_bit;
			COMPARATOR_RESULT_PIN_OE <= pin_enable;
			TIMER_CAPTURE_IN <= capture_route & result_bit;
			TIMER_CHANNEL_ZERO_PIN_BLOCK <= capture_route;
		end
	end

	// AXI4-Lite write side: address and data taken in either order
	reg aw_held;
	reg w_held;
	reg [3:0] aw_addr;
	reg [7:0] w_byte;
	reg w_lane0;

	assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
	assign S_AXI_WREADY = ~w_held & ~S_AXI_BVALID;

	wire aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
	wire w_fire = S_AXI_WVALID & S_AXI_WREADY;
	wire have_aw = aw_held | aw_fire;
	wire have_w = w_held | w_fire;
	wire [3:0] wr_addr = aw_held ? aw_addr : S_AXI_AWADDR;
	wire [7:0] wr_byte = w_held ? w_byte : S_AXI_WDATA[7:0];
	wire wr_lane0 = w_held ? w_lane0 : S_AXI_WSTRB[0];
	wire do_write = have_aw & have_w & ~S_AXI_BVALID;
	wire wr_ctrl = do_write & wr_lane0 & (wr_addr == `CMPEV_OFF_CTRL);
	wire wr_sys = do_write & wr_lane0 & (wr_addr == `CMPEV_OFF_SYSOPT);
	wire wr_known = (wr_addr == `CMPEV_OFF_CTRL) |
		(wr_addr == `CMPEV_OFF_SYSOPT);
	wire flag_clear = wr_ctrl & wr_byte[`CMPEV_BIT_FLAG];

	always @(posedge SYS_CLK) begin
		if (blk_rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `CMPEV_RESP_OKAY;
		end else begin
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_known ? `CMPEV_RESP_OKAY :
					`CMPEV_RESP_SLVERR;
			end else begin
				if (aw_fire) begin
					aw_held <= 1'b1;
					aw_addr <= S_AXI_AWADDR;
				end
				if (w_fire) begin
					w_held <= 1'b1;
					w_byte <= S_AXI_WDATA[7:0];
					w_lane0 <= S_AXI_WSTRB[0];
				end
				if (S_AXI_BVALID & S_AXI_BREADY)
					S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// register fields; a new event beats a same-cycle clear
	always @(posedge SYS_CLK) begin
		if (blk_rst) begin
			module_enable <= 1'b0;
			ref_select <= 1'b0;
			int_enable <= 1'b0;
			pin_enable <= 1'b0;
			event_mode <= 2'h0;
			event_flag <= 1'b0;
			capture_route <= `CMPEV_SYSOPT_RESET;
		end else begin
			if (wr_ctrl) begin
				module_enable <= wr_byte[`CMPEV_BIT_ENABLE];
				ref_select <= wr_byte[`CMPEV_BIT_REFSEL];
				int_enable <= wr_byte[`CMPEV_BIT_IE];
				pin_enable <= wr_byte[`CMPEV_BIT_PINEN];
				event_mode <=
					wr_byte[`CMPEV_MODE_HI:`CMPEV_MODE_LO];
			end
			if (wr_sys)
				capture_route <= wr_byte[`CMPEV_BIT_CAPROUTE];
			if (event_hit)
				event_flag <= 1'b1;
			else if (flag_clear)
				event_flag <= 1'b0;
		end
	end

	// read side: one read at a time, data registered
	wire [7:0] ctrl_view = {module_enable, ref_select, event_flag,
		int_enable, result_bit, pin_enable, event_mode};

	assign S_AXI_ARREADY = ~S_AXI_RVALID;

	always @(posedge SYS_CLK) begin
		if (blk_rst) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `CMPEV_RESP_OKAY;
		end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			case (S_AXI_ARADDR)
				`CMPEV_OFF_CTRL: begin
					S_AXI_RDATA <= {24'h000000, ctrl_view};
					S_AXI_RRESP <= `CMPEV_RESP_OKAY;
				end
				`CMPEV_OFF_SYSOPT: begin
					S_AXI_RDATA <= {31'h00000000, capture_route};
					S_AXI_RRESP <= `CMPEV_RESP_OKAY;
				end
				default: begin
					S_AXI_RDATA <= 32'h00000000;
					S_AXI_RRESP <= `CMPEV_RESP_SLVERR;
				end
			endcase
		end else if (S_AXI_RVALID & S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// ---- sim/cmpev_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module cmpev_monitor (
	input wire SYS_CLK,
	input wire RESET,
	input wire STOP2_POWERDOWN,
	input wire CMP_RESULT_RAW,
	input wire CMP_POWER_ON,
	input wire IRQ,
	input wire COMPARATOR_RESULT_PIN,
	input wire COMPARATOR_RESULT_PIN_OE,
	input wire S_AXI_AWVALID,
	input wire S_AXI_AWREADY,
	input wire S_AXI_WVALID,
	input wire S_AXI_WREADY,
	input wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire [31:0] S_AXI_RDATA
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	sequence wr_go;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	// four cycles covers the synchroniser plus the pin register
	sequence pin_live;
		(CMP_POWER_ON && COMPARATOR_RESULT_PIN_OE)[*4];
	endsequence
	rst_clear_a: assert property ($past(RESET) |-> !CMP_POWER_ON && !IRQ)
		else $error("outputs not clear after reset");
	stop2_clear_a: assert property (STOP2_POWERDOWN |=> !CMP_POWER_ON && !IRQ)
		else $error("outputs not clear in stop2");
	pin_lag_a: assert property (pin_live |->
		COMPARATOR_RESULT_PIN == $past(CMP_RESULT_RAW, 3))
		else $error("pin does not follow result");
	wr_resp_a: assert property (wr_go |=> S_AXI_BVALID)
		else $error("write response missing");
	rd_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read response missing");
	b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");
	r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data not held");
	rd_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule
bind cmpev_top cmpev_monitor u_mon (.*);
`default_nettype wire

// ---- sim/cmpev_core.sv ----
`timescale 1ns/100ps
`default_nettype none
module cmpev_core #(parameter int REF_MV = 600) (
	input wire logic refsel,
	input wire logic [15:0] plus_mv,
	input wire logic [15:0] minus_mv,
	output logic result
);
	// reference assumed buffered, software turns the buffer on first
	assign result = (refsel ? REF_MV : plus_mv) > minus_mv;
endmodule
`default_nettype wire

// ---- sim/cmpev_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic SYS_CLK, RESET, STOP2_POWERDOWN, CMP_RESULT_RAW, CMP_POWER_ON, IRQ;
	logic REFERENCE_SELECT, COMPARATOR_RESULT_PIN, COMPARATOR_RESULT_PIN_OE;
	logic TIMER_CAPTURE_IN, TIMER_CHANNEL_ZERO_PIN_BLOCK, S_AXI_AWVALID;
	logic S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
	logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	logic [3:0] S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rv;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rr;
	logic [15:0] lf, minus_mv;
	int mismatches, num_checks, cyc;
	bit en, rs, fl, ie, pe, rte, old;
	bit [1:0] md;
	cmpev_top u_dut (.*);
	cmpev_core u_core (.refsel(REFERENCE_SELECT), .plus_mv(16'h01f4),
		.minus_mv(minus_mv), .result(CMP_RESULT_RAW));
	task automatic chk(input string n, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= {24'h0, d};
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		do @(posedge SYS_CLK); while (!(S_AXI_AWREADY && S_AXI_WREADY));
		S_AXI_AWVALID <= 1'b0;
		S_AXI_WVALID <= 1'b0;
		@(posedge SYS_CLK);
		S_AXI_BREADY <= 1'b1;
		do @(posedge SYS_CLK); while (!S_AXI_BVALID);
		S_AXI_BREADY <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge SYS_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		do @(posedge SYS_CLK); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 1'b0;
		@(posedge SYS_CLK);
		S_AXI_RREADY <= 1'b1;
		do @(posedge SYS_CLK); while (!S_AXI_RVALID);
		rv = S_AXI_RDATA;
		rr = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
	endtask
	task automatic wctl(input bit c);
		wr(4'h0, {en, rs, c, ie, 1'b0, pe, md});
		if (c)
			fl = 0;
	endtask
	task automatic setraw(input bit v);
		minus_mv <= v ? 16'h00c8 : 16'h0320;
		repeat (6) @(posedge SYS_CLK);
		if (en && v != old && (md == 2'h3 || (md == 2'h1) == v))
			fl = 1;
		old = v;
	endtask
	task automatic chkall();
		rd(4'h0);
		chk("ctrl", rv, {en, rs, fl, ie, en & old, pe, md});
		chk("resp", rr, 2'h0);
		chk("irq", IRQ, fl & ie);
		chk("pins", {CMP_POWER_ON, REFERENCE_SELECT, COMPARATOR_RESULT_PIN_OE,
			COMPARATOR_RESULT_PIN & pe}, {en, rs, pe, pe & en & old});
		chk("cap", {TIMER_CHANNEL_ZERO_PIN_BLOCK, TIMER_CAPTURE_IN},
			{rte, rte & en & old});
	endtask
	initial begin
		SYS_CLK = 0;
		forever #25 SYS_CLK = ~SYS_CLK;
	end
	always @(posedge SYS_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		{RESET, STOP2_POWERDOWN, S_AXI_AWVALID, S_AXI_WVALID} = 4'h8;
		{S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 3'h0;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB} = 12'h00f;
		S_AXI_WDATA = 32'h0;
		minus_mv = 16'h0320;
		lf = 16'he95e;
		repeat (3) @(posedge SYS_CLK);
		RESET <= 1'b0;
		chkall();
		rd(4'h8);
		chk("unmapped", {rr, rv}, {2'h2, 32'h0});
		for (int i = 0; i < 4; i++) begin
			lf = lfsr(lf);
			{rs, rte} = lf[1:0];
			{en, ie, pe, md} = {1'b1, i[0], ~i[1], i[1:0]};
			wr(4'h4, {7'h0, rte});
			wctl(1'b1);
			setraw(1'b1);
			chkall();
			wctl(1'b0);
			chkall();
			setraw(1'b0);
			chkall();
		end
		en = 0;
		wctl(1'b1);
		setraw(1'b1);
		chkall();
		STOP2_POWERDOWN <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		STOP2_POWERDOWN <= 1'b0;
		{rs, ie, pe, rte, md} = 6'h0;
		chkall();
		final_report();
	end
endmodule
`default_nettype wire
